// ### hdl/irq_timer.sv
// Interrupt status, mask, input change and 16-bit counter/timer.
// ----------------------------------------------------------------------
// Summary of operation
// - Input change flags 7:4 set on pin change, all cleared when the register is read.
// - Reading the input change register also clears status bit 7.
// - Input change bits 3:0 return live pin levels at the read.
// - Interrupt output low when any status bit and its mask bit are both one.
// - Status reads return unmasked status regardless of the mask.
// - Interrupt status clears to zero on reset.
// - Status bit 7 set only for changes on inputs enabled by the change field.
// - Break change bits 6 and 2 set on break edge, clear on reset-break command.
// - Receiver-ready mode: set on character in, clear on read, reset if more remain.
// - FIFO-full mode: set when FIFO fills, clear on read, reset on waiting load.
// - Bits 4 and 0 mirror channel transmitter-ready flags.
// - Counter mode: counter-ready sets at zero, clears on stop command.
// - Timer mode: counter-ready sets every second zero; stop clears it, timer keeps running.
// - The mask does not affect programmable port interrupt outputs.
// - Preload is two write-only bytes; host must not load below two.
// - Timer mode square wave period is twice the preload in source clocks.
// - Preload rewrite in timer mode takes effect at the next half-period.
// - Idle until start read at address E; start restarts; read at F stops counter mode only.
// - Counter mode counts down from preload, continues past zero until stopped.
// - Counter output high until terminal count, then low; high again on stop.
// - Counter mode preload takes effect only at next start; old one reused.
// - Live counter halves readable; host should stop counter first.
// - Three-bit field picks mode and source: 0-3 counter, 4-7 timer.
// ----------------------------------------------------------------------
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "irq_timer_consts.svh"
module irq_timer (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [3:0] input_pin_in,
	input wire logic chan_a_tx_clk_in,
	input wire logic chan_b_tx_clk_in,
	input wire logic xtal_clk_in,
	input wire irq_timer_pkg::chan_evt_s chan_a_evt_in,
	input wire irq_timer_pkg::chan_evt_s chan_b_evt_in,
	input wire logic chan_a_fifo_full_mode_in,
	input wire logic chan_b_fifo_full_mode_in,
	input wire logic chan_a_brk_reset_in,
	input wire logic chan_b_brk_reset_in,
	output logic [7:0] rdata_out,
	output logic irq_out_n,
	output logic output_port_bit3_out
);
	// ------------------------------------------------------------------
	// Register bus decode
	// ------------------------------------------------------------------
	logic [3:0] pin_lvl;
	logic [3:0] pin_prev_ff;
	logic [3:0] change_ff;
	logic [7:0] isr_ff;
	logic [7:0] nxt_isr;
	logic [7:0] mask_ff;
	logic [6:0] acr_ff;
	logic [15:0] preload_ff;
	logic [15:0] count_ff;
	logic [15:0] nxt_count;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic irq_n_ff;
	logic op3_ff;
	logic nxt_op3;
	logic half_ff;
	logic nxt_half;
	logic ctr_flag_ff;
	logic nxt_ctr_flag;
	logic [3:0] pre_ff;
	irq_timer_pkg::ct_state_e state_ff;
	irq_timer_pkg::ct_state_e nxt_state;
	wire rd_change = rd_in && addr_in == `ADDR_INPUT_CHANGE;
	wire rd_start = rd_in && addr_in == `ADDR_START_CMD;
	wire rd_stop = rd_in && addr_in == `ADDR_STOP_CMD;
	wire wr_acr = wr_in && addr_in == `ADDR_AUX_CONTROL;
	wire wr_mask = wr_in && addr_in == `ADDR_INT_MASK;
	wire wr_pre_hi = wr_in && addr_in == `ADDR_PRELOAD_UPPER;
	wire wr_pre_lo = wr_in && addr_in == `ADDR_PRELOAD_LOWER;
	wire timer_mode = acr_ff[`BIT_ACR_TIMER];
	wire [2:0] src_sel = acr_ff[6:4];
	// ------------------------------------------------------------------
	// Input pin synchronisers and change detection
	// ------------------------------------------------------------------
	logic [3:0] pin_rise_unused;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			edge_sync u_pin (
				.core_clk_in(core_clk_in),
				.srst_in(srst_in),
				.async_in(input_pin_in[gi]),
				.level_out(pin_lvl[gi]),
				.rise_out(pin_rise_unused[gi])
			);
		end
	endgenerate
	wire [3:0] pin_delta = pin_lvl ^ pin_prev_ff;
	wire [3:0] nxt_change = pin_delta | (rd_change ? 4'h0 : change_ff);
	// ------------------------------------------------------------------
	// Counter clock source selection
	// ------------------------------------------------------------------
	logic txa_lvl;
	logic txa_rise;
	logic txb_lvl;
	logic txb_rise;
	logic xtal_lvl;
	logic xtal_rise;
	edge_sync u_txa (
		.core_clk_in(core_clk_in),
		.srst_in(srst_in),
		.async_in(chan_a_tx_clk_in),
		.level_out(txa_lvl),
		.rise_out(txa_rise)
	);
	edge_sync u_txb (
		.core_clk_in(core_clk_in),
		.srst_in(srst_in),
		.async_in(chan_b_tx_clk_in),
		.level_out(txb_lvl),
		.rise_out(txb_rise)
	);
	edge_sync u_xtal (
		.core_clk_in(core_clk_in),
		.srst_in(srst_in),
		.async_in(xtal_clk_in),
		.level_out(xtal_lvl),
		.rise_out(xtal_rise)
	);
	// IP2 rising edge, taken from the already synchronised level.
	wire ip2_rise = pin_lvl[2] & ~pin_prev_ff[2];
	wire pre_src = (src_sel == `SRC_T_IP2_16) ? ip2_rise : xtal_rise;
	wire pre_tick = pre_src && pre_ff == `PRESCALE_LAST;
	logic src_tick;
	always_comb begin
		unique case (src_sel)
			`SRC_IP2, `SRC_T_IP2: src_tick = ip2_rise;
			`SRC_TXA: src_tick = txa_rise;
			`SRC_TXB: src_tick = txb_rise;
			`SRC_T_XTAL: src_tick = xtal_rise;
			default: src_tick = pre_tick;
		endcase
	end
	// ------------------------------------------------------------------
	// Counter/timer
	// ------------------------------------------------------------------
	function automatic logic [15:0] dec16(input logic [15:0] v);
		dec16 = v - `WORD_ONE;
	endfunction : dec16
	wire at_one = count_ff == `WORD_ONE;
	always_comb begin
		nxt_state = state_ff;
		nxt_count = count_ff;
		nxt_half = half_ff;
		nxt_op3 = op3_ff;
		nxt_ctr_flag = ctr_flag_ff;
		unique case (state_ff)
			irq_timer_pkg::CT_IDLE: begin
				nxt_op3 = 1'b1;
			end
			irq_timer_pkg::CT_COUNT: begin
				if (src_tick) begin
					nxt_count = dec16(count_ff);
					if (at_one) begin
						nxt_ctr_flag = 1'b1;
						nxt_op3 = 1'b0;
					end
				end
			end
			irq_timer_pkg::CT_TIMER: begin
				if (src_tick) begin
					if (at_one) begin
						// Reload from the live preload: a rewrite only hits later halves.
						nxt_count = preload_ff;
						nxt_half = ~half_ff;
						nxt_op3 = ~op3_ff;
						if (half_ff) begin
							nxt_ctr_flag = 1'b1;
						end
					end else begin
						nxt_count = dec16(count_ff);
					end
				end
			end
			default: nxt_state = irq_timer_pkg::CT_IDLE;
		endcase
		if (rd_stop) begin
			nxt_ctr_flag = 1'b0;
			if (!timer_mode) begin
				nxt_state = irq_timer_pkg::CT_IDLE;
				nxt_op3 = 1'b1;
			end
		end
		if (rd_start) begin
			// Start aborts any cycle and reloads from the preload.
			nxt_count = preload_ff;
			nxt_half = 1'b0;
			nxt_op3 = 1'b1;
			nxt_state = timer_mode ? irq_timer_pkg::CT_TIMER : irq_timer_pkg::CT_COUNT;
		end
	end
	// ------------------------------------------------------------------
	// Interrupt status
	// ------------------------------------------------------------------
	function automatic logic rx_bit(input irq_timer_pkg::chan_evt_s e, input logic full_mode,
		input logic cur);
		logic set;
		set = full_mode ? ((e.rx_char_in && e.rx_fifo_full) || e.rx_waiting_load)
			: (e.rx_char_in || (e.rx_pop && e.rx_fifo_nonempty));
		rx_bit = set | (cur & ~e.rx_pop);
	endfunction : rx_bit
	wire in_chg_set = |(pin_delta & acr_ff[3:0]);
	always_comb begin
		nxt_isr = isr_ff;
		nxt_isr[`BIT_ISR_INPUT] = in_chg_set | (isr_ff[`BIT_ISR_INPUT] & ~rd_change);
		nxt_isr[`BIT_ISR_BRK_B] = chan_b_evt_in.brk_change
			| (isr_ff[`BIT_ISR_BRK_B] & ~chan_b_brk_reset_in);
		nxt_isr[`BIT_ISR_BRK_A] = chan_a_evt_in.brk_change
			| (isr_ff[`BIT_ISR_BRK_A] & ~chan_a_brk_reset_in);
		nxt_isr[`BIT_ISR_RX_B] = rx_bit(chan_b_evt_in, chan_b_fifo_full_mode_in,
			isr_ff[`BIT_ISR_RX_B]);
		nxt_isr[`BIT_ISR_RX_A] = rx_bit(chan_a_evt_in, chan_a_fifo_full_mode_in,
			isr_ff[`BIT_ISR_RX_A]);
		nxt_isr[`BIT_ISR_TX_B] = chan_b_evt_in.tx_ready;
		nxt_isr[`BIT_ISR_TX_A] = chan_a_evt_in.tx_ready;
		nxt_isr[`BIT_ISR_CTR] = nxt_ctr_flag;
	end
	// ------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------
	always_comb begin
		nxt_rdata = `BYTE_ZERO;
		unique case (addr_in)
			`ADDR_INPUT_CHANGE: nxt_rdata = {change_ff, pin_lvl};
			`ADDR_INT_STATUS: nxt_rdata = isr_ff;
			`ADDR_COUNT_UPPER: nxt_rdata = count_ff[15:8];
			`ADDR_COUNT_LOWER: nxt_rdata = count_ff[7:0];
			default: nxt_rdata = `BYTE_ZERO;
		endcase
		if (!rd_in) begin
			nxt_rdata = `BYTE_ZERO;
		end
	end
	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			isr_ff <= `ISR_RESET;
			mask_ff <= `BYTE_ZERO;
			acr_ff <= 7'h00;
			preload_ff <= `PRELOAD_MIN;
			change_ff <= 4'h0;
			pin_prev_ff <= 4'h0;
			rdata_ff <= `BYTE_ZERO;
			irq_n_ff <= 1'b1;
		end else begin
			isr_ff <= nxt_isr;
			change_ff <= nxt_change;
			pin_prev_ff <= pin_lvl;
			rdata_ff <= nxt_rdata;
			irq_n_ff <= ~|(nxt_isr & (wr_mask ? wdata_in : mask_ff));
			if (wr_mask) mask_ff <= wdata_in;
			if (wr_acr) acr_ff <= wdata_in[6:0];
			if (wr_pre_hi) preload_ff[15:8] <= wdata_in;
			if (wr_pre_lo) preload_ff[7:0] <= wdata_in;
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			state_ff <= irq_timer_pkg::CT_IDLE;
			count_ff <= `WORD_ZERO;
			half_ff <= 1'b0;
			op3_ff <= 1'b1;
			ctr_flag_ff <= 1'b0;
			pre_ff <= 4'h0;
		end else begin
			state_ff <= nxt_state;
			count_ff <= nxt_count;
			half_ff <= nxt_half;
			op3_ff <= nxt_op3;
			ctr_flag_ff <= nxt_ctr_flag;
			if (pre_src) pre_ff <= pre_ff + 4'h1;
		end
	end
	// The port output ignores the mask entirely.
	assign rdata_out = rdata_ff;
	assign irq_out_n = irq_n_ff;
	assign output_port_bit3_out = op3_ff;
endmodule : irq_timer

// ### hdl/irq_timer_consts.svh
// Register offsets, field positions, reset values and encodings for the interrupt/timer block.
`ifndef IRQ_TIMER_CONSTS_SVH
`define IRQ_TIMER_CONSTS_SVH
`define ADDR_INPUT_CHANGE 4'h4
`define ADDR_AUX_CONTROL 4'h4
`define ADDR_INT_STATUS 4'h5
`define ADDR_INT_MASK 4'h5
`define ADDR_COUNT_UPPER 4'h6
`define ADDR_COUNT_LOWER 4'h7
`define ADDR_PRELOAD_UPPER 4'h6
`define ADDR_PRELOAD_LOWER 4'h7
`define ADDR_START_CMD 4'he
`define ADDR_STOP_CMD 4'hf
`define ADDR_CHAN_CTRL 4'h8
`define BIT_ISR_INPUT 7
`define BIT_ISR_BRK_B 6
`define BIT_ISR_RX_B 5
`define BIT_ISR_TX_B 4
`define BIT_ISR_CTR 3
`define BIT_ISR_BRK_A 2
`define BIT_ISR_RX_A 1
`define BIT_ISR_TX_A 0
`define BIT_ACR_TIMER 6
`define BIT_TXRDY 2
`define ISR_RESET 8'h00
`define BYTE_ZERO 8'h00
`define WORD_ZERO 16'h0000
`define WORD_ONE 16'h0001
`define PRELOAD_MIN 16'h0002
`define PRESCALE_LAST 4'hf
`define SRC_IP2 3'h0
`define SRC_TXA 3'h1
`define SRC_TXB 3'h2
`define SRC_XTAL16 3'h3
`define SRC_T_IP2 3'h4
`define SRC_T_IP2_16 3'h5
`define SRC_T_XTAL 3'h6
`define SRC_T_XTAL16 3'h7
`endif

// ### hdl/irq_timer_pkg.sv
// Types shared by the interrupt status and counter/timer block.
package irq_timer_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;
	typedef struct packed {
		logic rx_char_in;
		logic rx_fifo_full;
		logic rx_pop;
		logic rx_fifo_nonempty;
		logic rx_waiting_load;
		logic brk_change;
		logic tx_ready;
	} chan_evt_s;
	typedef enum logic [2:0] {
		CT_IDLE = 3'b001,
		CT_COUNT = 3'b010,
		CT_TIMER = 3'b100
	} ct_state_e;
endpackage : irq_timer_pkg

// ### hdl/edge_sync.sv
// Two-flop synchroniser with a rising-edge pulse output.
`timescale 1ns/1ps
module edge_sync (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic async_in,
	output logic level_out,
	output logic rise_out
);
	logic meta_ff;
	logic sync_ff;
	logic prev_ff;
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end
	assign level_out = sync_ff;
	assign rise_out = sync_ff & ~prev_ff;
endmodule : edge_sync

// ### tb/irq_timer_properties.sv
// Port-level assertions for the interrupt status and counter/timer block.
`timescale 1ns/1ps
module irq_timer_properties (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [3:0] input_pin_in,
	input wire irq_timer_pkg::chan_evt_s chan_a_evt_in,
	input wire irq_timer_pkg::chan_evt_s chan_b_evt_in,
	input wire logic [7:0] rdata_out,
	input wire logic irq_out_n,
	input wire logic output_port_bit3_out
);
	// ----------
	// Shadow state
	// ----------
	logic [7:0] mask_ff;
	logic timer_ff;
	logic [3:0] pin_ff;
	logic [2:0] quiet_ff;
	wire logic rd4 = rd_in && addr_in == 4'h4;
	wire logic rd5 = rd_in && addr_in == 4'h5;
	wire logic stop = rd_in && addr_in == 4'hf && !timer_ff;
	wire logic [2:0] nxt_quiet = (input_pin_in != pin_ff) ? 3'h0 : quiet_ff + {2'h0, quiet_ff != 3'h7};
	always_ff @(posedge core_clk_in) begin
		pin_ff <= input_pin_in;
		if (srst_in) begin
			mask_ff <= 8'h00;
			timer_ff <= 1'b0;
			quiet_ff <= 3'h0;
		end else begin
			mask_ff <= (wr_in && addr_in == 4'h5) ? wdata_in : mask_ff;
			timer_ff <= (wr_in && addr_in == 4'h4) ? wdata_in[6] : timer_ff;
			quiet_ff <= nxt_quiet;
		end
	end
	// ----------
	// Assertions
	// ----------
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (srst_in);
	AST_RESET_IDLE: assert property (disable iff (1'b0) srst_in [*2] |->
		irq_out_n && rdata_out == 8'h00) else $error("reset outputs");
	AST_LIVE_PINS: assert property (rd4 && quiet_ff > 3'h3 |=>
		rdata_out[3:0] == $past(input_pin_in)) else $error("live pins");
	AST_CHANGE_CLEAR: assert property (rd4 ##2 (rd4 && quiet_ff > 3'h5) |=>
		rdata_out[7:4] == 4'h0) else $error("change flags");
	AST_SUMMARY_CLEAR: assert property (rd4 ##2 (rd5 && quiet_ff > 3'h5) |=>
		!rdata_out[7]) else $error("summary bit");
	AST_IRQ_MASK: assert property (rd5 && $stable(mask_ff) |=> $stable(mask_ff) &&
		$past(irq_out_n) == !(|(rdata_out & mask_ff))) else $error("irq level");
	AST_TX_MIRROR: assert property (($stable(chan_a_evt_in.tx_ready) &&
		$stable(chan_b_evt_in.tx_ready)) [*4] ##0 rd5 |=> rdata_out[0] == chan_a_evt_in.tx_ready
		&& rdata_out[4] == chan_b_evt_in.tx_ready) else $error("ready mirror");
	AST_STOP_HIGH: assert property (stop |=> output_port_bit3_out)
		else $error("stop output");
	AST_STOP_CLEARS: assert property (stop ##2 rd5 |=> !rdata_out[3])
		else $error("stop status");
	COV_CHANGE_READ: cover property (rd4 ##2 rd4);
	COV_IRQ_LOW: cover property (!irq_out_n);
	COV_STOP_STATUS: cover property (stop ##2 rd5);
endmodule : irq_timer_properties
bind irq_timer irq_timer_properties i_irq_timer_properties (.core_clk_in, .srst_in, .addr_in,
	.wdata_in, .wr_in, .rd_in, .input_pin_in, .chan_a_evt_in, .chan_b_evt_in, .rdata_out,
	.irq_out_n, .output_port_bit3_out);

// ### tb/host.sv
// Host processor model that drives the register bus.
`timescale 1ns/1ps
module host (
	input wire logic core_clk_in,
	input wire logic [7:0] rdata_in,
	output irq_timer_pkg::reg_req_s req_out
);
	// ----------
	// Bus cycles
	// ----------
	// Every access ends with an idle cycle, so a strobe is never set twice in one step.
	initial req_out = 14'h0000;
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		req_out <= {a, d, 2'b10};
		@(posedge core_clk_in);
		req_out <= 14'h0000;
		@(posedge core_clk_in);
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		req_out <= {a, 8'h00, 2'b01};
		@(posedge core_clk_in);
		req_out <= 14'h0000;
		@(posedge core_clk_in);
		d = rdata_in;
	endtask : rd
	task automatic ld(input logic [15:0] v);
		wr(4'h6, v[15:8]);
		wr(4'h7, v[7:0]);
	endtask : ld
	// Halves are read apart, so a tick in between would tear the value.
	task automatic cnt(output logic [15:0] v);
		rd(4'h6, v[15:8]);
		rd(4'h7, v[7:0]);
	endtask : cnt
endmodule : host

// ### tb/irq_timer_tb_top.sv
// Self-checking bench for the interrupt status and counter/timer block.
`timescale 1ns/1ps
module irq_timer_tb_top;
	logic core_clk_in;
	logic srst_in;
	logic [3:0] pins;
	logic [1:0] ffm;
	logic [1:0] brk;
	logic txclk;
	irq_timer_pkg::chan_evt_s evt_a;
	irq_timer_pkg::chan_evt_s evt_b;
	irq_timer_pkg::reg_req_s req;
	logic [7:0] rdata;
	logic irq_n;
	logic op3;
	logic [7:0] got;
	logic [15:0] val;
	int failures;
	int checks_done;
	irq_timer i_irq_timer (.core_clk_in(core_clk_in), .srst_in(srst_in), .addr_in(req.addr),
		.wdata_in(req.wdata), .wr_in(req.wr), .rd_in(req.rd), .input_pin_in(pins),
		.chan_a_tx_clk_in(txclk), .chan_b_tx_clk_in(txclk), .xtal_clk_in(1'b0),
		.chan_a_evt_in(evt_a), .chan_b_evt_in(evt_b), .chan_a_fifo_full_mode_in(ffm[0]),
		.chan_b_fifo_full_mode_in(ffm[1]), .chan_a_brk_reset_in(brk[0]),
		.chan_b_brk_reset_in(brk[1]), .rdata_out(rdata), .irq_out_n(irq_n),
		.output_port_bit3_out(op3));
	host i_host (.core_clk_in(core_clk_in), .rdata_in(rdata), .req_out(req));
	// ----------
	// Helpers
	// ----------
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
	endtask : tick
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] act);
		checks_done++;
		if (act !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, act);
		end
	endtask : check
	task automatic rdx(input logic [3:0] a, input logic [7:0] exp);
		i_host.rd(a, got);
		check("reg", {8'h00, exp}, {8'h00, got});
	endtask : rdx
	task automatic bit1(input string what, input logic exp, input logic act);
		check(what, {15'h0000, exp}, {15'h0000, act});
	endtask : bit1
	task automatic cnt(input logic [15:0] exp);
		i_host.cnt(val);
		check("count", exp, val);
	endtask : cnt
	task automatic pulse(input logic c, input logic [6:0] p);
		if (c) begin
			evt_b <= evt_b | p;
		end else begin
			evt_a <= evt_a | p;
		end
		tick(1);
		evt_a <= evt_a & ~p;
		evt_b <= evt_b & ~p;
		tick(6);
	endtask : pulse
	task automatic ip2(input int n);
		repeat (n) begin
			pins[2] <= 1'b1;
			tick(4);
			pins[2] <= 1'b0;
			tick(6);
		end
	endtask : ip2
	task automatic end_of_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	initial begin
		core_clk_in = 1'b0;
		forever #12.5 core_clk_in = ~core_clk_in;
	end
	initial begin
		tick(20000);
		failures++;
		end_of_test();
	end
	initial begin
		srst_in = 1'b1;
		pins = 4'h0;
		ffm = 2'b00;
		brk = 2'b00;
		txclk = 1'b0;
		evt_a = 7'h00;
		evt_b = 7'h00;
		failures = 0;
		checks_done = 0;
		tick(16);
		srst_in <= 1'b0;
		tick(1);
		rdx(4'h5, 8'h00);
		i_host.wr(4'h4, 8'h01);
		pins <= 4'h3;
		tick(8);
		rdx(4'h5, 8'h80);
		bit1("irq", 1'b1, irq_n);
		i_host.wr(4'h5, 8'h80);
		tick(2);
		bit1("irq", 1'b0, irq_n);
		rdx(4'h4, 8'h33);
		rdx(4'h4, 8'h03);
		rdx(4'h5, 8'h00);
		bit1("irq", 1'b1, irq_n);
		pins <= 4'h1;
		tick(8);
		rdx(4'h5, 8'h00);
		rdx(4'h4, 8'h21);
		for (int c = 0; c < 2; c++) begin
			pulse(c[0], 7'h02);
			rdx(4'h5, 8'h04 << 4 * c);
			brk[c] <= 1'b1;
			tick(1);
			brk <= 2'b00;
			tick(2);
			rdx(4'h5, 8'h00);
			pulse(c[0], 7'h40);
			pulse(c[0], 7'h18);
			rdx(4'h5, 8'h02 << 4 * c);
			pulse(c[0], 7'h10);
			rdx(4'h5, 8'h00);
			ffm[c] <= 1'b1;
			pulse(c[0], 7'h40);
			rdx(4'h5, 8'h00);
			pulse(c[0], 7'h60);
			pulse(c[0], 7'h10);
			pulse(c[0], 7'h04);
			rdx(4'h5, 8'h02 << 4 * c);
			pulse(c[0], 7'h10);
			ffm[c] <= 1'b0;
		end
		evt_a.tx_ready <= 1'b1;
		evt_b.tx_ready <= 1'b1;
		tick(4);
		rdx(4'h5, 8'h11);
		evt_a.tx_ready <= 1'b0;
		evt_b.tx_ready <= 1'b0;
		i_host.ld(16'h0003);
		i_host.rd(4'he, got);
		bit1("op3", 1'b1, op3);
		cnt(16'h0003);
		ip2(3);
		bit1("op3", 1'b0, op3);
		rdx(4'h5, 8'h08);
		ip2(1);
		i_host.ld(16'h0005);
		cnt(16'hffff);
		i_host.rd(4'hf, got);
		bit1("op3", 1'b1, op3);
		rdx(4'h5, 8'h00);
		ip2(1);
		cnt(16'hffff);
		i_host.rd(4'he, got);
		cnt(16'h0005);
		i_host.wr(4'h4, 8'h41);
		i_host.ld(16'h0002);
		i_host.rd(4'he, got);
		ip2(2);
		bit1("op3", 1'b0, op3);
		rdx(4'h5, 8'h00);
		ip2(2);
		bit1("op3", 1'b1, op3);
		rdx(4'h5, 8'h08);
		i_host.rd(4'hf, got);
		rdx(4'h5, 8'h00);
		ip2(2);
		bit1("op3", 1'b0, op3);
		i_host.ld(16'h0003);
		ip2(2);
		bit1("op3", 1'b1, op3);
		ip2(2);
		bit1("op3", 1'b1, op3);
		ip2(1);
		bit1("op3", 1'b0, op3);
		for (int s = 1; s < 3; s++) begin
			i_host.wr(4'h4, 8'(s << 4));
			i_host.ld(16'h0004);
			i_host.rd(4'he, got);
			repeat (4) begin
				txclk <= ~txclk;
				tick(5);
			end
			cnt(16'h0002);
		end
		end_of_test();
	end
endmodule : irq_timer_tb_top
